// >>> design/ivp_pkg.sv
// ivp_pkg: constants for the interrupt vector and priority block
// assumes a 10 MHz core clock and a plain strobe register port
// Behaviour
// R01: addresses below the vector-area top hold only fixed vectors, never application code
// R02: after any reset the program counter starts at the reset vector, address zero
// R03: software places a jump at zero; its target lies in the next word
// R04: two vector tables span 0x000004..0x0000FF and 0x000100..0x0001FF
// R05: every source owns a distinct entry and so its own service routine
// R06: priority fields are three bits; codes one to seven, seven highest
// R07: a zero priority field disables its source completely
// R08: timer two priority in bits 14:12, output compare two in 10:8
// R09: input capture two priority in bits 6:4, dma zero done in 2:0
// R10: bits 15, 11, 7 and 3 of the priority register read zero
// R11: disable counter sits at 0x0052; top two bits unimplemented
// R12: cpu level joins the top bit above three bits; top bit blocks user interrupts
// R13: after reset every priority field holds 100, level four
// R14: highest enabled pending priority wins, only above the current cpu level
package ivp_pkg;
  localparam int          ADDR_W          = 16;
  localparam int          DATA_W          = 16;
  localparam int          PC_W            = 24;
  localparam int          PRIO_W          = 3;
  localparam int          NUM_SRC         = 4;
  localparam int          VEC_IDX_W       = 7;
  localparam int          CNT_W           = 14;
  localparam logic [15:0] OFS_DISABLE_CNT = 16'h0052;
  localparam logic [15:0] OFS_PRIO_ONE    = 16'h00A6;
  localparam logic [23:0] RESET_VECTOR    = 24'h000000;
  localparam logic [23:0] GOTO_TARGET_AT  = 24'h000002;
  localparam logic [23:0] TABLE_ONE_BASE  = 24'h000004;
  localparam logic [23:0] TABLE_ONE_END   = 24'h0000FF;
  localparam logic [23:0] TABLE_TWO_BASE  = 24'h000100;
  localparam logic [23:0] TABLE_TWO_END   = 24'h0001FF;
  localparam logic [23:0] VECTOR_AREA_TOP = 24'h000200;
  localparam logic [15:0] PRIO_ONE_MASK   = 16'h7777;
  localparam logic [15:0] PRIO_ONE_RESET  = 16'h4444;
  localparam logic [15:0] CNT_MASK        = 16'h3FFF;
  localparam logic [2:0]  PRIO_OFF        = 3'h0;
  localparam int          LSB_TIMER_TWO   = 12;
  localparam int          LSB_OC_TWO      = 8;
  localparam int          LSB_IC_TWO      = 4;
  localparam int          LSB_DMA_ZERO    = 0;
  // source vector numbers, one per source
  localparam logic [6:0]  VEC_OC_TWO      = 7'h0A;
  localparam logic [6:0]  VEC_IC_TWO      = 7'h0B;
  localparam logic [6:0]  VEC_TIMER_TWO   = 7'h0D;
  localparam logic [6:0]  VEC_DMA_ZERO    = 7'h0E;
  localparam logic [6:0]  VEC_NONE        = 7'h00;

  typedef enum logic [1:0] {
    IVP_RUN   = 2'b00,
    IVP_TAKEN = 2'b01
  } ivp_state_type;

  // each entry is one instruction word, two address units wide
  function automatic logic [23:0] vec_addr(input logic [6:0] idx, input logic alt);
    vec_addr = (alt ? TABLE_TWO_BASE : TABLE_ONE_BASE) + {16'h0000, idx, 1'b0};
  endfunction
endpackage

// >>> design/ivp_arbiter.sv
// ivp_arbiter: picks the pending source of highest priority
// assumes request levels held by peripherals until serviced
`timescale 1ns/10ps
module ivp_arbiter #(
  parameter int NSRC = ivp_pkg::NUM_SRC
) (
  input  wire logic [NSRC-1:0]                 req,
  input  wire logic [NSRC*ivp_pkg::PRIO_W-1:0] prio,
  input  wire logic [ivp_pkg::VEC_IDX_W*NSRC-1:0] vec,
  output logic                                 hit,
  output logic [ivp_pkg::PRIO_W-1:0]           win_prio,
  output logic [ivp_pkg::VEC_IDX_W-1:0]        win_vec,
  output logic [NSRC-1:0]                      win_onehot
);
  import ivp_pkg::*;
  initial begin
    if (NSRC < 1) $error("ivp_arbiter needs at least one source");
  end
  always_comb begin
    hit        = 1'b0;
    win_prio   = PRIO_OFF;
    win_vec    = VEC_NONE;
    win_onehot = '0;
    // lower index wins a tie; fixed order keeps service predictable
    for (int i = 0; i < NSRC; i++) begin
      if (req[i] && prio[i*PRIO_W +: PRIO_W] != PRIO_OFF && // [R07]
          (!hit || prio[i*PRIO_W +: PRIO_W] > win_prio)) begin // [R14]
        hit        = 1'b1;
        win_prio   = prio[i*PRIO_W +: PRIO_W];
        win_vec    = vec[i*VEC_IDX_W +: VEC_IDX_W]; // [R05]
        win_onehot = '0;
        win_onehot[i] = 1'b1;
      end
    end
  end
endmodule

// >>> design/ivp_top.sv
// ivp_top: interrupt vector and source priority logic
// assumes the core acknowledges a vector with one-cycle vec_ack
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
module ivp_top (
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  input  wire logic                        clk_en,
  input  wire logic [ivp_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [ivp_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [ivp_pkg::DATA_W-1:0]  reg_rdata,
  input  wire logic                        timer_two_req,
  input  wire logic                        output_compare_two_req,
  input  wire logic                        input_capture_two_req,
  input  wire logic                        dma_zero_done_req,
  input  wire logic [ivp_pkg::PRIO_W-1:0]  cpu_priority_level,
  input  wire logic                        cpu_priority_level_top_bit,
  input  wire logic                        alt_table_sel,
  input  wire logic                        disi_load,
  input  wire logic [ivp_pkg::CNT_W-1:0]   disi_value,
  input  wire logic                        instr_retire,
  input  wire logic                        vec_ack,
  output logic                             irq_req,
  output logic      [ivp_pkg::PRIO_W-1:0]  irq_prio,
  output logic      [ivp_pkg::PC_W-1:0]    irq_vector_addr,
  output logic      [ivp_pkg::PC_W-1:0]    reset_pc,
  output logic                             disable_active,
  output logic      [3:0]                  src_ack
);
  import ivp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [15:0]         prio_one_r;
  logic [CNT_W-1:0]    disable_cnt_r;
  logic [DATA_W-1:0]   rdata_nxt;
  logic                hit;
  logic [PRIO_W-1:0]   win_prio;
  logic [VEC_IDX_W-1:0] win_vec;
  logic [3:0]          win_onehot;
  logic [3:0]          req_v;
  logic [4*PRIO_W-1:0] prio_v;
  logic [4*VEC_IDX_W-1:0] vec_v;
  logic                allow;
  ivp_state_type       state_r;

  ////////////////////////////////////////////////////////////////////////////
  // register writes; reserved bits never store
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prio_one_r <= PRIO_ONE_RESET; // [R13]
    end else if (clk_en && reg_wr && reg_addr == OFS_PRIO_ONE) begin
      prio_one_r <= reg_wdata & PRIO_ONE_MASK; // [R10]
    end
  end

  // counter content is undefined at reset by nature; zero is chosen so
  // interrupts are not held off after reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      disable_cnt_r <= '0;
    end else if (clk_en) begin
      if (reg_wr && reg_addr == OFS_DISABLE_CNT) begin
        disable_cnt_r <= reg_wdata[CNT_W-1:0]; // [R11]
      end else if (disi_load) begin
        disable_cnt_r <= disi_value;
      end else if (instr_retire && disable_cnt_r != '0) begin
        disable_cnt_r <= disable_cnt_r - 1'b1;
      end
    end
  end

  always_comb begin
    rdata_nxt = '0;
    unique case (reg_addr)
      OFS_PRIO_ONE:    rdata_nxt = prio_one_r & PRIO_ONE_MASK; // [R10]
      OFS_DISABLE_CNT: rdata_nxt = {2'b00, disable_cnt_r} & CNT_MASK; // [R11]
      default:         rdata_nxt = '0;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rdata_nxt : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source fields gathered for the arbiter
  assign req_v  = {dma_zero_done_req, input_capture_two_req,
                   output_compare_two_req, timer_two_req};
  assign prio_v = {prio_one_r[LSB_DMA_ZERO +: PRIO_W], // [R09]
                   prio_one_r[LSB_IC_TWO +: PRIO_W],
                   prio_one_r[LSB_OC_TWO +: PRIO_W], // [R08]
                   prio_one_r[LSB_TIMER_TWO +: PRIO_W]};
  assign vec_v  = {VEC_DMA_ZERO, VEC_IC_TWO, VEC_OC_TWO, VEC_TIMER_TWO};

  ivp_arbiter #(.NSRC(4)) u_arb (
    .req        (req_v),
    .prio       (prio_v),
    .vec        (vec_v),
    .hit        (hit),
    .win_prio   (win_prio),
    .win_vec    (win_vec),
    .win_onehot (win_onehot)
  );

  // top bit set means level above seven, so no user source can pass
  assign allow = hit && !cpu_priority_level_top_bit && // [R12]
                 win_prio > cpu_priority_level && // [R14]
                 disable_cnt_r == '0;
  assign disable_active = disable_cnt_r != '0;

  ////////////////////////////////////////////////////////////////////////////
  // request held with vector registered; vec_ack drops it for two cycles, the one in IVP_TAKEN and the first back in IVP_RUN
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r         <= IVP_RUN;
      irq_req         <= 1'b0;
      irq_prio        <= PRIO_OFF;
      irq_vector_addr <= RESET_VECTOR;
      src_ack         <= '0;
    end else if (clk_en) begin
      src_ack <= '0;
      unique case (state_r)
        IVP_RUN: begin
          irq_req <= allow;
          if (allow) begin
            irq_prio        <= win_prio;
            irq_vector_addr <= vec_addr(win_vec, alt_table_sel); // [R04] [R05]
          end
          if (irq_req && vec_ack) begin
            irq_req <= 1'b0;
            src_ack <= win_onehot;
            state_r <= IVP_TAKEN;
          end
        end
        IVP_TAKEN: begin
          irq_req <= 1'b0;
          state_r <= IVP_RUN;
        end
        default: state_r <= IVP_RUN;
      endcase
    end
  end

  // reset vector is fixed; the image supplies a jump there
  assign reset_pc = RESET_VECTOR; // [R02] [R03]

  ////////////////////////////////////////////////////////////////////////////
  a_vec_in_area: assert property (@(posedge core_clk) disable iff (rst)
    irq_req |-> irq_vector_addr >= TABLE_ONE_BASE &&
                irq_vector_addr < VECTOR_AREA_TOP) // [R01]
    else $error("vector outside reserved area");
  a_reset_pc_zero: assert property (@(posedge core_clk) disable iff (rst)
    reset_pc == RESET_VECTOR) // [R02]
    else $error("reset pc not zero");
  a_table_range: assert property (@(posedge core_clk) disable iff (rst)
    irq_req |-> (alt_table_sel ? 1'b1 : irq_vector_addr <= TABLE_ONE_END) ||
                irq_vector_addr <= TABLE_TWO_END) // [R04]
    else $error("vector beyond tables");
  a_off_silent: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && prio_one_r == '0) |=> !irq_req || $past(irq_req)) // [R07]
    else $error("disabled source raised request");
  a_rsv_zero: assert property (@(posedge core_clk) disable iff (rst)
    (prio_one_r & ~PRIO_ONE_MASK) == '0) // [R10]
    else $error("reserved priority bits set");
  a_cnt_top_zero: assert property (@(posedge core_clk) disable iff (rst)
    $past(reg_rd && reg_addr == OFS_DISABLE_CNT && clk_en) |-> reg_rdata[15:14] == 2'b00) // [R11]
    else $error("counter top bits not zero");
  a_top_bit_block: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && cpu_priority_level_top_bit && !irq_req) |=> !irq_req) // [R12]
    else $error("request with top level bit set");
  a_level_above: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && allow && state_r == IVP_RUN && !(irq_req && vec_ack)) |=>
      irq_req && irq_prio == $past(win_prio)) // [R14] [R06]
    else $error("winning priority not presented");
endmodule

// >>> verif/ivp_core_model.sv
// ivp_core_model: cpu core side that accepts vectors from ivp_top
// assumes irq_req is a registered level that drops after vec_ack
`timescale 1ns/10ps
module ivp_core_model (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       irq_req,
  input  wire logic [3:0] ack_dly,
  output logic            vec_ack
);
  logic [3:0] wait_r;
  ////////////////////////////////////////////////////////////////////////////
  // ack_dly of zero never acknowledges, so the request stands for the bench to inspect
  // a slow core (large ack_dly) leaves the request standing longer before vec_ack
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wait_r  <= 4'h0;
      vec_ack <= 1'b0;
    end else begin
      vec_ack <= 1'b0;
      if (irq_req && (ack_dly != 4'h0) && !vec_ack) begin
        if (wait_r + 4'h1 >= ack_dly) begin
          vec_ack <= 1'b1;
          wait_r  <= 4'h0;
        end else begin
          wait_r <= wait_r + 4'h1;
        end
      end else begin
        wait_r <= 4'h0;
      end
    end
  end
endmodule

// >>> verif/tb_top.sv
// tb_top: self-checking bench for ivp_top
// assumes ivp_core_model answers vectors after ack_dly cycles
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_top;
  import ivp_pkg::*;
  logic        core_clk = 0, rst = 1, clk_en = 1, reg_wr = 0, reg_rd = 0;
  logic        alt_table_sel = 0, disi_load = 0, instr_retire = 0, top = 0;
  logic [15:0] reg_addr = 0, reg_wdata = 0, prio_m = 16'h4444, wd;
  logic [3:0]  req = 0, ack_dly = 0;
  logic [2:0]  lvl = 0;
  logic [13:0] disi_value = 0;
  wire logic [15:0] reg_rdata;
  wire logic        irq_req, vec_ack, disable_active;
  wire logic [2:0]  irq_prio;
  wire logic [23:0] irq_vector_addr, reset_pc;
  wire logic [3:0]  src_ack;
  int          bad_count = 0, samples_checked = 0, cyc = 0, cnt_m = 0;
  ////////////////////////////////////////////////////////////////////////////
  ivp_top i_ivp_top (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .timer_two_req(req[0]), .output_compare_two_req(req[1]),
    .input_capture_two_req(req[2]), .dma_zero_done_req(req[3]),
    .cpu_priority_level(lvl), .cpu_priority_level_top_bit(top),
    .alt_table_sel(alt_table_sel), .disi_load(disi_load), .disi_value(disi_value),
    .instr_retire(instr_retire), .vec_ack(vec_ack), .irq_req(irq_req),
    .irq_prio(irq_prio), .irq_vector_addr(irq_vector_addr), .reset_pc(reset_pc),
    .disable_active(disable_active), .src_ack(src_ack));
  ivp_core_model i_ivp_core_model (.core_clk(core_clk), .rst(rst), .irq_req(irq_req),
    .ack_dly(ack_dly), .vec_ack(vec_ack));
  always #50 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1;
    @(posedge core_clk);
    reg_wr <= 0;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [15:0] e, input string n);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1;
    @(posedge core_clk);
    reg_rd <= 0;
    #1 `CHK(n, e, reg_rdata)
  endtask
  // behavioural winner: strict > keeps the lowest index on a tie
  task automatic chk_irq();
    int best, idx, p;
    logic [6:0] v[4];
    logic [23:0] ea;
    v = '{VEC_TIMER_TWO, VEC_OC_TWO, VEC_IC_TWO, VEC_DMA_ZERO};
    best = 0;
    idx = 0;
    for (int i = 0; i < 4; i++) begin
      p = (prio_m >> (12 - 4 * i)) & 7;
      if (req[i] && p > best) begin
        best = p;
        idx = i;
      end
    end
    ea = (alt_table_sel ? TABLE_TWO_BASE : TABLE_ONE_BASE) + 24'(2 * v[idx]);
    `CHK("irq_req", (best > lvl && !top && cnt_m == 0), irq_req)
    if (irq_req === 1'b1) begin
      `CHK("irq_prio", 3'(best), irq_prio)
      `CHK("vector", ea, irq_vector_addr)
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(54));
    repeat (6) @(posedge core_clk);
    rst <= 0;
    #1 `CHK("reset_pc", RESET_VECTOR, reset_pc)
    rd_chk(OFS_PRIO_ONE, 16'h4444, "prio_rst");
    rd_chk(OFS_DISABLE_CNT, 16'h0000, "cnt_rst");
    rd_chk(16'h0054, 16'h0000, "unmapped");
    @(posedge core_clk);
    clk_en    <= 0;
    reg_addr  <= OFS_PRIO_ONE;
    reg_wdata <= 16'h0000;
    reg_wr    <= 1;
    @(posedge core_clk);
    reg_wr <= 0;
    clk_en <= 1;
    rd_chk(OFS_PRIO_ONE, 16'h4444, "prio_frozen");
    wr(OFS_DISABLE_CNT, 16'hFFFF);
    rd_chk(OFS_DISABLE_CNT, 16'h3FFF, "cnt_top");
    wr(OFS_DISABLE_CNT, 16'h0000);
    for (int k = 0; k < 60; k++) begin
      wd = 16'($urandom());
      wr(OFS_PRIO_ONE, wd);
      prio_m = wd & 16'h7777;
      rd_chk(OFS_PRIO_ONE, prio_m, "prio_rw");
      req <= 4'($urandom());
      lvl <= 3'($urandom());
      top <= ($urandom() % 8) == 0;
      alt_table_sel <= 1'($urandom());
      repeat (3) @(posedge core_clk);
      #1 chk_irq();
      @(posedge core_clk);
      req <= 0;
      repeat (2) @(posedge core_clk);
    end
    wr(OFS_PRIO_ONE, 16'h1357);
    prio_m = 16'h1357;
    for (int s = 0; s < 4; s++) begin
      @(posedge core_clk);
      req <= 4'h1 << s;
      lvl <= 0;
      top <= 0;
      ack_dly <= 4'(1 + 3 * s);
      repeat (20) begin
        @(posedge core_clk);
        #1 if (vec_ack === 1'b1) break;
      end
      @(posedge core_clk);
      #1 `CHK("src_ack", 4'h1 << s, src_ack)
      `CHK("irq_drop", 1'b0, irq_req)
      @(posedge core_clk);
      req <= 0;
      ack_dly <= 0;
      repeat (3) @(posedge core_clk);
    end
    @(posedge core_clk);
    req <= 4'hF;
    disi_value <= 14'd3;
    disi_load <= 1;
    @(posedge core_clk);
    disi_load <= 0;
    cnt_m = 3;
    repeat (2) @(posedge core_clk);
    #1 `CHK("dis_on", 1'b1, disable_active)
    chk_irq();
    repeat (3) begin
      @(posedge core_clk);
      instr_retire <= 1;
    end
    @(posedge core_clk);
    instr_retire <= 0;
    cnt_m = 0;
    repeat (2) @(posedge core_clk);
    #1 `CHK("dis_off", 1'b0, disable_active)
    chk_irq();
    wrap_up();
  end
endmodule
